// ===== verilog/mst_pkg.sv
/*
  Shared constants and types for the memory self-test and init block.
  Assumes a 250 MHz bus clock and one shared memory command port.
*/
package mst_pkg;
  // Clock figures; the ROM clock divider never goes below the derived floor
  localparam int BUS_CLK_MHZ = 250;
  localparam int ROM_CLK_MAX_MHZ = 100;
  localparam int ROM_DIV_MIN = (BUS_CLK_MHZ + ROM_CLK_MAX_MHZ - 1) / ROM_CLK_MAX_MHZ;
  localparam int MEM_AW = 14;
  localparam int MEM_WORDS = 16384;
  localparam int NUM_INIT = 17;
  localparam int NUM_GRP = 32;
  localparam int NUM_EV = 4;
  localparam int NUM_SPI = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] ADDR_TEST_GCR = 32'h0fff_ff58;
  localparam logic [31:0] ADDR_INIT_GCR = 32'h0fff_ff5c;
  localparam logic [31:0] ADDR_INIT_SEL = 32'h0fff_ff60;
  localparam logic [31:0] ADDR_DOM_SEL = 32'h0fff_ff64;
  localparam logic [31:0] ADDR_STATUS = 32'h0fff_ff68;
  localparam logic [31:0] ADDR_MASK = 32'h0fff_ff6c;
  localparam logic [31:0] ADDR_STATE = 32'h0fff_ff70;

  // Test and init global control fields
  localparam int GCR_DIV_LSB = 0;
  localparam int GCR_START = 4;
  localparam int GCR_ALGO_LSB = 8;
  localparam int GCR_GRP_LSB = 16;
  localparam int INIT_START = 0;
  localparam logic [31:0] TEST_GCR_RESET = 32'h0000_0800;

  // One-hot algorithm mask
  localparam logic [3:0] ALGO_TRIPLE_SLOW = 4'h1;
  localparam logic [3:0] ALGO_TRIPLE_FAST = 4'h2;
  localparam logic [3:0] ALGO_MARCH_DP = 4'h4;
  localparam logic [3:0] ALGO_MARCH_SP = 4'h8;

  // Self-test groups by memory kind
  localparam logic [4:0] GRP_BANK_A = 5'h06;
  localparam logic [4:0] GRP_BANK_B = 5'h15;
  localparam logic [31:0] GRP_ROM = 32'h0000_0006;
  localparam logic [31:0] GRP_SINGLE = 32'h0020_0040;
  localparam logic [31:0] GRP_DUAL = 32'h001c_7fb8;

  // Init select map: main banks, DMA, IRQ vectors, timers, units, CAN, SPI, ADC
  localparam int INIT_MAIN = 0;
  localparam logic [NUM_INIT-1:0] INIT_PRESENT = 17'h1_ddff;
  localparam logic [NUM_INIT-1:0] INIT_ODD_PAR = 17'h1_ddfe;
  localparam int SPI_BIT0 = 7;
  localparam int SPI_BIT1 = 11;
  localparam int SPI_BIT2 = 12;

  // Status and state register bits
  localparam int ST_TEST_DONE = 0;
  localparam int ST_INIT_DONE = 1;
  localparam int ST_TEST_FAIL = 2;
  localparam int ST_ALGO_ERR = 3;
  localparam int STA_TEST_BUSY = 0;
  localparam int STA_INIT_BUSY = 1;

  // Check-bit masks: seven syndrome bits plus overall parity in bit 7
  localparam logic [6:0][31:0] ECC_MASK = '{
    32'h5555_5555, 32'h6666_6666, 32'h7878_7878, 32'h7f80_7f80,
    32'h7fff_8000, 32'h8000_0000, 32'hffff_fffe};

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic req;
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [31:0] wdata;
    logic [7:0] chk;
  } mst_mem_cmd_t;

  typedef enum {
    S_IDLE, S_W0, S_RD, S_WAIT, S_CMP, S_ROM_RD, S_ROM_CMP, S_SCAN, S_INIT_WR
  } mst_state_t;
endpackage

// ===== verilog/mst_rom_div.sv
/*
  ROM clock divider: a one-cycle tick at the divided ROM rate.
  Assumes the divide field is stable while the test engine runs.
*/
`timescale 1ns/10ps
module mst_rom_div import mst_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Divide select, divide by sel+1 with a floor
  input wire logic [1:0] div_sel,
  output logic tick
);
  logic [2:0] cnt;
  logic [2:0] top;

  always_comb begin
    top = 3'(div_sel) ;
    if (int'(div_sel) + 1 < ROM_DIV_MIN) begin
      top = 3'(ROM_DIV_MIN - 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 3'h0;
      tick <= 1'b0;
    end else if (cnt >= top) begin
      cnt <= 3'h0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 3'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ===== verilog/mst_addr_walk.sv
/*
  Word address walker shared by the test engine and the init sequencer.
  Start takes priority when start and step are raised together.
*/
`timescale 1ns/10ps
module mst_addr_walk import mst_pkg::*; #(
  parameter int WORDS = MEM_WORDS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  input wire logic step,
  // Position
  output logic [MEM_AW-1:0] addr,
  output logic last
);
  assign last = (addr == MEM_AW'(WORDS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr <= '0;
    end else if (start) begin
      addr <= '0;
    end else if (step && !last) begin
      addr <= addr + MEM_AW'(1);
    end
  end
endmodule

// ===== verilog/mst_ctrl.sv
/*
  Memory self-test engine and hardware init sequencer with AXI4-Lite registers.
  Assumes memory read data is valid the cycle after a read command shows.
*/
`timescale 1ns/10ps
// Summary of operation
// R01: ROM accesses are paced by a clock no faster than 100 MHz.
// R02: ROM clock divided from bus clock by the global control divide field.
// R03: One-hot algorithm mask: 1 slow, 2 fast triple read, 4/8 March.
// R04: Main bank A is single-port group 6, tested with single-port March.
// R05: Main bank B is single-port group 21, tested with single-port March.
// R06: Software should prefer March for RAM; other algorithms stay selectable (code rejects any non-March algorithm on a RAM group).
// R07: Each group is tested alone, never needing another group.
// R08: Init writes known data with matching parity or ECC check bits.
// R09: Init control register starts the sequence; select register picks memories.
// R10: Select bits map main banks, DMA, vectors, timers, CAN, SPI, ADC.
// R11: Main RAM power domain bits choose which domains init touches.
// R12: Each SPI module self-inits its RAMs on release from local reset.
// R13: Software releases SPI local reset before requesting system init of it.
// R14: Finishing a test or init sets a done flag, pollable or interrupting.
// R15: Memories under test or init are held from normal access.
module mst_ctrl import mst_pkg::*; #(
  parameter int WORDS = MEM_WORDS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory port
  output mst_mem_cmd_t mem_cmd,
  input wire logic [31:0] mem_rdata,
  output logic [NUM_GRP-1:0] test_hold,
  output logic [NUM_INIT-1:0] init_hold,
  output logic [NUM_INIT-1:0] mem_init_target,
  output logic [1:0] main_ram_domain_en,
  // SPI local reset status and self-init requests
  input wire logic [NUM_SPI-1:0] spi_rst_released,
  output logic [NUM_SPI-1:0] spi_self_init,
  // Interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic aw_full, w_full, wr_do, rd_clr;
  logic [31:0] awaddr_q, wdata_q;
  logic [31:0] test_gcr;
  logic [NUM_INIT-1:0] init_sel;
  logic [1:0] dom_sel;
  logic [NUM_EV-1:0] status, mask, ev;
  logic test_go, test_go_q, init_go, algo_ok, is_rom, rom_tick, rom_ph, fail;
  logic [3:0] algo;
  logic [4:0] grp;
  logic [1:0] pass, rcnt;
  logic [31:0] rom_first;
  logic [4:0] idx;
  logic [NUM_INIT-1:0] init_eff;
  logic [NUM_SPI-1:0] spi_s1, spi_s2, spi_s3;
  logic walk_start, walk_step, walk_last;
  logic [MEM_AW-1:0] walk_addr;
  mst_state_t state;

  function automatic logic [7:0] chk_calc(input logic [31:0] d, input logic odd);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < 7; i++) begin
      c[i] = ^(d & ECC_MASK[i]);
    end
    c[7] = (^d) ^ odd;
    return c;
  endfunction

  assign wr_do = aw_full && w_full && !s_axi_bvalid;
  assign rd_clr = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_STATUS);
  assign algo = test_gcr[GCR_ALGO_LSB +: 4];
  assign grp = test_gcr[GCR_GRP_LSB +: 5];
  assign is_rom = GRP_ROM[grp];
  assign test_go = wr_do && (awaddr_q == ADDR_TEST_GCR) && wdata_q[GCR_START];
  assign init_go = wr_do && (awaddr_q == ADDR_INIT_GCR) && wdata_q[INIT_START];
  assign algo_ok = (GRP_ROM[grp] && (algo == ALGO_TRIPLE_SLOW || algo == ALGO_TRIPLE_FAST))
                || (GRP_DUAL[grp] && algo == ALGO_MARCH_DP)
                || (GRP_SINGLE[grp] && algo == ALGO_MARCH_SP); // [R03] [R04] [R05]

  // Selected, present memories; SPI RAMs still in local reset are skipped [R13]
  always_comb begin
    init_eff = init_sel & INIT_PRESENT; // [R10]
    init_eff[SPI_BIT0] = init_eff[SPI_BIT0] & spi_s2[0];
    init_eff[SPI_BIT1] = init_eff[SPI_BIT1] & spi_s2[1];
    init_eff[SPI_BIT2] = init_eff[SPI_BIT2] & spi_s2[2];
    if (dom_sel == 2'h0) begin
      init_eff[INIT_MAIN] = 1'b0; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        wdata_q <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q inside {ADDR_TEST_GCR, ADDR_INIT_GCR, ADDR_INIT_SEL,
                         ADDR_DOM_SEL, ADDR_STATUS, ADDR_MASK, ADDR_STATE}) ?
                       AXI_OKAY : AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable registers; byte strobes are kept in a latched form
  logic [3:0] wstrb_q;
  logic [31:0] wm_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wstrb_q <= s_axi_wstrb;
    end
  end
  assign wm_q = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_gcr <= TEST_GCR_RESET;
      init_sel <= '0;
      dom_sel <= 2'h3;
      mask <= '0;
    end else if (wr_do && state == S_IDLE) begin
      unique case (awaddr_q)
        ADDR_TEST_GCR: test_gcr <= (test_gcr & ~wm_q) | (wdata_q & wm_q); // [R02]
        ADDR_INIT_SEL: init_sel <= NUM_INIT'((init_sel & ~wm_q) | (wdata_q & wm_q)); // [R09]
        ADDR_DOM_SEL: dom_sel <= 2'((dom_sel & ~wm_q) | (wdata_q & wm_q)); // [R11]
        ADDR_MASK: mask <= NUM_EV'((mask & ~wm_q) | (wdata_q & wm_q));
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      unique case (s_axi_araddr)
        ADDR_TEST_GCR: s_axi_rdata <= test_gcr & ~(32'h1 << GCR_START);
        ADDR_INIT_GCR: s_axi_rdata <= {31'h0, state inside {S_SCAN, S_INIT_WR}};
        ADDR_INIT_SEL: s_axi_rdata <= 32'(init_sel);
        ADDR_DOM_SEL: s_axi_rdata <= 32'(dom_sel);
        ADDR_STATUS: s_axi_rdata <= 32'(status);
        ADDR_MASK: s_axi_rdata <= 32'(mask);
        ADDR_STATE: s_axi_rdata <= {grp, 24'h0, idx == 5'h0,
                                    |init_hold, |test_hold};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, mask and interrupt; a new event wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= (rd_clr ? '0 : status) | ev; // [R14]
      irq <= |(((rd_clr ? '0 : status) | ev) & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI local reset release and self-init requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spi_s1 <= '0;
      spi_s2 <= '0;
      spi_s3 <= '0;
      spi_self_init <= '0;
    end else begin
      spi_s1 <= spi_rst_released;
      spi_s2 <= spi_s1;
      spi_s3 <= spi_s2;
      spi_self_init <= spi_s2 & ~spi_s3; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  mst_rom_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_sel(test_gcr[GCR_DIV_LSB +: 2]),
    .tick(rom_tick)
  );

  mst_addr_walk #(.WORDS(WORDS)) u_walk (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(walk_start),
    .step(walk_step),
    .addr(walk_addr),
    .last(walk_last)
  );

  assign walk_start = (state == S_IDLE) || (state == S_SCAN)
                   || (state == S_CMP && walk_last && pass == 2'h1)
                   || (state == S_W0 && walk_last);
  assign walk_step = (state == S_W0) || (state == S_CMP) || (state == S_INIT_WR)
                  || (state == S_ROM_CMP && rcnt == 2'h2 && !mem_cmd.req);

  ////////////////////////////////////////////////////////////////////////////
  // Test and init sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      mem_cmd <= '0;
      test_hold <= '0;
      init_hold <= '0;
      mem_init_target <= '0;
      main_ram_domain_en <= 2'h0;
      pass <= 2'h0;
      rcnt <= 2'h0;
      rom_ph <= 1'b0;
      rom_first <= '0;
      fail <= 1'b0;
      idx <= 5'h0;
      ev <= '0;
      test_go_q <= 1'b0;
    end else begin
      ev <= '0;
      mem_cmd <= '0;
      // Start acts a cycle late so it sees the fields written along with it
      test_go_q <= test_go && state == S_IDLE;
      unique case (state)
        S_IDLE: begin
          idx <= 5'h0;
          pass <= 2'h0;
          rcnt <= 2'h0;
          fail <= 1'b0;
          if (test_go_q && !algo_ok) begin
            ev[ST_ALGO_ERR] <= 1'b1; // [R03]
            ev[ST_TEST_DONE] <= 1'b1;
          end else if (test_go_q) begin
            test_hold <= NUM_GRP'(1) << grp; // [R07] [R15]
            state <= is_rom ? S_ROM_RD : S_W0;
          end else if (init_go) begin
            init_hold <= init_eff; // [R09] [R15]
            state <= S_SCAN;
          end
        end
        S_W0: begin
          mem_cmd <= '{1'b1, 1'b1, walk_addr, 32'h0, 8'h0};
          if (walk_last) begin
            pass <= 2'h1;
            state <= S_RD;
          end
        end
        S_RD: begin
          mem_cmd <= '{1'b1, 1'b0, walk_addr, 32'h0, 8'h0};
          state <= S_WAIT;
        end
        S_WAIT: state <= S_CMP;
        S_CMP: begin
          if (mem_rdata != ((pass == 2'h1) ? 32'h0 : 32'hffff_ffff)) begin
            fail <= 1'b1;
          end
          if (pass == 2'h1) begin
            mem_cmd <= '{1'b1, 1'b1, walk_addr, 32'hffff_ffff, 8'h0};
          end
          state <= S_RD;
          if (walk_last && pass == 2'h1) begin
            pass <= 2'h2;
          end else if (walk_last) begin
            state <= S_IDLE;
            test_hold <= '0;
            ev[ST_TEST_DONE] <= 1'b1; // [R14]
            ev[ST_TEST_FAIL] <= fail || (mem_rdata != 32'hffff_ffff);
          end
        end
        S_ROM_RD: begin
          // Slow triple read uses every other divided tick
          if (rom_tick) begin
            rom_ph <= ~rom_ph;
            if (algo == ALGO_TRIPLE_FAST || rom_ph) begin
              mem_cmd <= '{1'b1, 1'b0, walk_addr, 32'h0, 8'h0}; // [R01]
              state <= S_ROM_CMP;
            end
          end
        end
        S_ROM_CMP: begin
          // Read data stands the cycle after the command has shown
          if (!mem_cmd.req) begin
            if (rcnt == 2'h0) begin
              rom_first <= mem_rdata;
            end else if (mem_rdata != rom_first) begin
              fail <= 1'b1;
            end
            rcnt <= (rcnt == 2'h2) ? 2'h0 : rcnt + 2'h1;
            state <= S_ROM_RD;
            if (rcnt == 2'h2 && walk_last) begin
              state <= S_IDLE;
              test_hold <= '0;
              ev[ST_TEST_DONE] <= 1'b1; // [R14]
              ev[ST_TEST_FAIL] <= fail || (mem_rdata != rom_first);
            end
          end
        end
        S_SCAN: begin
          mem_init_target <= '0;
          main_ram_domain_en <= 2'h0;
          if (idx == 5'(NUM_INIT)) begin
            state <= S_IDLE;
            init_hold <= '0;
            ev[ST_INIT_DONE] <= 1'b1; // [R14]
          end else if (init_hold[idx]) begin
            mem_init_target <= NUM_INIT'(1) << idx; // [R10]
            main_ram_domain_en <= (idx == 5'(INIT_MAIN)) ? dom_sel : 2'h0; // [R11]
            state <= S_INIT_WR;
          end else begin
            idx <= idx + 5'h1;
          end
        end
        S_INIT_WR: begin
          mem_cmd <= '{1'b1, 1'b1, walk_addr, 32'h0,
                       chk_calc(32'h0, INIT_ODD_PAR[idx])}; // [R08]
          if (walk_last) begin
            idx <= idx + 5'h1;
            state <= S_SCAN;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_rom_read;
    mem_cmd.req && !mem_cmd.we && (test_hold & GRP_ROM) != '0;
  endsequence
  sequence s_init_start;
    state == S_IDLE && init_go && init_eff != '0;
  endsequence

  a_rom_pace: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
    s_rom_read |-> $past(rom_tick)) else $error("ROM read without divided tick");
  a_div_floor: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
    rom_tick |=> !rom_tick [*2]) else $error("ROM clock faster than its limit");
  a_algo_reject: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
    state == S_IDLE && test_go_q && !algo_ok |=> state == S_IDLE ##1 status[ST_ALGO_ERR])
    else $error("Mismatched algorithm not rejected");
  a_bank_a_march: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
    test_hold[GRP_BANK_A] |-> algo == ALGO_MARCH_SP) else $error("Bank A wrong algorithm");
  a_bank_b_march: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
    test_hold[GRP_BANK_B] |-> algo == ALGO_MARCH_SP) else $error("Bank B wrong algorithm");
  a_group_alone: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
    $onehot0(test_hold) && !(test_hold != '0 && init_hold != '0))
    else $error("More than one group held");
  a_init_chk: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
    mem_cmd.req && mem_init_target != '0 |->
    mem_cmd.we && mem_cmd.wdata == 32'h0
    && mem_cmd.chk == {|(mem_init_target & INIT_ODD_PAR), 7'h0})
    else $error("Init check bits wrong");
  a_init_start: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
    s_init_start |=> init_hold != '0 ##[1:3] mem_init_target != '0)
    else $error("Init did not start");
  a_init_map: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    (mem_init_target & ~(init_sel & INIT_PRESENT)) == '0) else $error("Unselected init");
  a_dom_sel: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    main_ram_domain_en != 2'h0 |-> mem_init_target[INIT_MAIN] && main_ram_domain_en == dom_sel)
    else $error("Domain enable outside main RAM init");
  a_spi_self: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    $rose(spi_s2[0]) |=> spi_self_init[0]) else $error("SPI self-init missing");
  a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    state == S_SCAN && idx == 5'(NUM_INIT) |=> state == S_IDLE ##1 status[ST_INIT_DONE])
    else $error("Init done flag not set");
  a_hold_init: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    mem_init_target != '0 |-> (mem_init_target & ~init_hold) == '0)
    else $error("Init target not held");
endmodule

// ===== dv/mst_mem_model.sv
/*
  Memory model on the shared command port.
  Assumes one command per cycle; read data shows the cycle after.
*/
`timescale 1ns/10ps
module mst_mem_model import mst_pkg::*; #(
  parameter int WORDS = 8
) (
  // Clock
  input wire logic aclk,
  // Command and read data
  input wire mst_mem_cmd_t mem_cmd,
  output logic [31:0] mem_rdata,
  output logic [7:0] last_chk
);
  logic [31:0] mem [WORDS];
  initial begin
    mem_rdata = 32'h5a5a_a5a5;
    last_chk = 8'h00;
    foreach (mem[i]) mem[i] = 32'h3c3c_0000 + i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Idle cycles toggle the data so stale values never match
  always @(posedge aclk) begin
    if (mem_cmd.req && mem_cmd.we) begin
      mem[mem_cmd.addr] <= mem_cmd.wdata;
      last_chk <= mem_cmd.chk;
    end
    if (mem_cmd.req && !mem_cmd.we) mem_rdata <= mem[mem_cmd.addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule

// ===== dv/testbench.sv
/*
  Register-level bench for the self-test and init block.
  Assumes the memory model above as the only memory.
*/
`timescale 1ns/10ps
module testbench;
  import mst_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] spi_rel = 0, spi_init;
  logic [NUM_GRP-1:0] test_hold;
  logic [7:0] last_chk;
  logic [31:0] mrd;
  mst_mem_cmd_t cmd;
  int err_total = 0, n_compared = 0;
  always #2 aclk = ~aclk;
  mst_ctrl #(.WORDS(8)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_cmd(cmd), .mem_rdata(mrd), .test_hold(test_hold),
    .init_hold(), .mem_init_target(), .main_ram_domain_en(),
    .spi_rst_released(spi_rel), .spi_self_init(spi_init), .irq(irq));
  mst_mem_model #(.WORDS(8)) mem_i (.aclk(aclk), .mem_cmd(cmd), .mem_rdata(mrd),
    .last_chk(last_chk));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0; resp = bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0; d = rdata; resp = rresp;
    @(posedge aclk);
  endtask
  // Polls the state register until idle; checks the test hold while a test is busy
  task automatic wait_idle(input logic [31:0] hold);
    int n;
    logic [NUM_GRP-1:0] h;
    n = 0;
    do begin
      h = test_hold;
      rd(ADDR_STATE);
      if (d[STA_TEST_BUSY]) chk(h, hold);
      n++;
    end while (d[1:0] != 2'b00 && n < 500);
    chk({30'h0, d[1:0]}, 32'h0);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rd(ADDR_TEST_GCR); chk(d, TEST_GCR_RESET);
    rd(ADDR_DOM_SEL); chk(d, 32'h3);
    rd(32'h0fff_ff80); chk(d, 32'h0);
    chk({30'h0, resp}, {30'h0, AXI_SLVERR});
    wr(32'h0fff_ff80, 32'h1); chk({30'h0, resp}, {30'h0, AXI_SLVERR});
    wr(ADDR_MASK, 32'h2);
    // Bank A alone with single-port March, then a wrong algorithm on bank B
    wr(ADDR_TEST_GCR, 32'h0006_0810);
    wait_idle(32'h0000_0040);
    chk(mem_i.mem[7], 32'hffff_ffff);
    rd(ADDR_STATUS); chk(d, 32'h1);
    rd(ADDR_STATUS); chk(d, 32'h0);
    wr(ADDR_TEST_GCR, 32'h0015_0410);
    wait_idle(32'h0020_0000);
    rd(ADDR_STATUS); chk(d, 32'h9);
    // Both ROM triple reads and the dual-port March finish clean
    wr(ADDR_TEST_GCR, 32'h0001_0210);
    wait_idle(32'h0000_0002);
    rd(ADDR_STATUS); chk(d, 32'h1);
    wr(ADDR_TEST_GCR, 32'h0002_0110);
    wait_idle(32'h0000_0004);
    rd(ADDR_STATUS); chk(d, 32'h1);
    wr(ADDR_TEST_GCR, 32'h0003_0410);
    wait_idle(32'h0000_0008);
    rd(ADDR_STATUS); chk(d, 32'h1);
    // Init of main banks and DMA RAM raises the masked interrupt
    wr(ADDR_INIT_SEL, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_INIT_GCR, 32'h1);
    wait_idle(32'h0);
    chk(mem_i.mem[7], 32'h0);
    chk({24'h0, last_chk}, 32'h80);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_STATUS); chk(d, 32'h2);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // Local reset release of one SPI module starts its own init
    spi_rel <= 3'b001;
    repeat (4) @(posedge aclk);
    chk({29'h0, spi_init}, 32'h1);
    @(posedge aclk);
    chk({29'h0, spi_init}, 32'h0);
    end_of_test;
  end
endmodule
